// ### hw/sbf_defs.svh
`ifndef SBF_DEFS_SVH
`define SBF_DEFS_SVH

// Word framing.
`define SBF_WORD_BITS   4'h8
`define SBF_ACK_SLOT    4'h8
`define SBF_ADDR_TAG    4'ha
`define SBF_REC_PULSES  4'h9

// Timing: system clock period and one quarter of the generated serial clock period.
`define SBF_CLK_NS      50
`define SBF_SCL_QTR_NS  250
`define SBF_QTR_CYC     ((`SBF_SCL_QTR_NS + `SBF_CLK_NS - 1) / `SBF_CLK_NS)

`endif

// ### hw/sbf_pkg.sv
package sbf_pkg;

	typedef enum logic [2:0] {
		SBF_CMD_START,
		SBF_CMD_STOP,
		SBF_CMD_WRITE,
		SBF_CMD_READ,
		SBF_CMD_RECOVER
	} sbf_cmd_type;

	typedef enum logic [2:0] {
		SBF_DS_IDLE,
		SBF_DS_RX,
		SBF_DS_ACK,
		SBF_DS_TX,
		SBF_DS_RDACK,
		SBF_DS_IGNORE
	} sbf_dev_state_type;

	typedef enum logic {
		SBF_HS_IDLE,
		SBF_HS_RUN
	} sbf_host_state_type;

endpackage

// ### hw/sbf_link_if.sv
`timescale 1ns/1ns
interface sbf_link_if;
	logic scl;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic sda;

	// Open-drain wire with pull-up: any enabled driver that outputs zero pulls the line low.
	assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

	modport dev (
		input  scl,
		input  sda,
		output dev_sda_out,
		output dev_sda_oe
	);

	modport host (
		output scl,
		input  sda,
		output host_sda_out,
		output host_sda_oe
	);
endinterface

// ### hw/sbf_dev.sv
`timescale 1ns/1ns
`include "sbf_defs.svh"
// Summary of operation
// - Data changes only while clock low
// - Data edge with clock high is framing
// - Start restarts reception at first bit
// - Nothing acted on before a start
// - Stop ends current transaction
// - Stop after read enters standby
// - Words are eight bits, one per pulse
// - Acknowledge low in ninth clock period
// - Standby from reset until start
// - Standby after stop once core idle
// - Recovery uses at most nine pulses
// - Recovery ends with start target accepts
// - Data line only pulled low, never driven
// - Address word top nibble is 1010
// - Address word bit zero selects read
// - Address mismatch: no acknowledge, standby
// - Busy core: ignore bus, no acknowledge
module sbf_dev
	import sbf_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Two-wire link.
	sbf_link_if.dev         link,
	// Target select and memory core status.
	input  wire logic [2:0] dev_sel_in,
	input  wire logic       core_busy_in,
	// Received words.
	output logic      [7:0] rx_data_out,
	output logic            rx_first_out,
	output logic            rx_valid_out,
	input  wire logic       rx_ready_in,
	// Words to send.
	input  wire logic [7:0] tx_data_in,
	output logic            tx_take_out,
	// Status.
	output logic            dir_read_out,
	output logic            stop_out,
	output logic            standby_out
);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic filt(input logic [2:0] s, input logic f);
		return (s[1] == s[2]) ? s[2] : f;
	endfunction

	function automatic logic addr_hit(input logic [7:0] w, input logic [2:0] sel);
		return (w[7:4] == `SBF_ADDR_TAG) && (w[3:1] == sel);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [2:0] scl_s_r;
	logic [2:0] scl_s_nxt;
	logic [2:0] sda_s_r;
	logic [2:0] sda_s_nxt;
	logic       scl_f_r;
	logic       scl_f_nxt;
	logic       sda_f_r;
	logic       sda_f_nxt;
	logic       scl_p_r;
	logic       sda_p_r;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_ev;
	logic       stop_ev;

	// The first stage feeds only the second; the filter looks at stages two and three.
	always_comb begin
		scl_s_nxt = {scl_s_r[1:0], link.scl};
		sda_s_nxt = {sda_s_r[1:0], link.sda};
		scl_f_nxt = filt(scl_s_r, scl_f_r);
		sda_f_nxt = filt(sda_s_r, sda_f_r);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
			scl_f_r <= 1'h1;
			sda_f_r <= 1'h1;
			scl_p_r <= 1'h1;
			sda_p_r <= 1'h1;
		end else begin
			scl_s_r <= scl_s_nxt;
			sda_s_r <= sda_s_nxt;
			scl_f_r <= scl_f_nxt;
			sda_f_r <= sda_f_nxt;
			scl_p_r <= scl_f_r;
			sda_p_r <= sda_f_r;
		end
	end

	assign scl_rise = scl_f_r && !scl_p_r;
	assign scl_fall = !scl_f_r && scl_p_r;
	// A data edge while the clock stays high is framing, never a data bit.
	assign start_ev = scl_f_r && scl_p_r && sda_p_r && !sda_f_r;
	assign stop_ev  = scl_f_r && scl_p_r && !sda_p_r && sda_f_r;

	////////////////////////////////////////////////////////////////////////////////
	// Two-entry receive buffer; slot 0 is the head shown at the outputs.
	logic [8:0] d0_r;
	logic [8:0] d0_nxt;
	logic [8:0] d1_r;
	logic [8:0] d1_nxt;
	logic       v0_r;
	logic       v0_nxt;
	logic       v1_r;
	logic       v1_nxt;
	logic       push;
	logic       pop;
	logic [8:0] push_word;

	assign pop = v0_r && rx_ready_in;

	always_comb begin
		d0_nxt = d0_r;
		d1_nxt = d1_r;
		v0_nxt = v0_r;
		v1_nxt = v1_r;
		if (pop) begin
			d0_nxt = d1_r;
			v0_nxt = v1_r;
			v1_nxt = 1'h0;
		end
		if (push) begin
			if (!v0_nxt) begin
				d0_nxt = push_word;
				v0_nxt = 1'h1;
			end else begin
				d1_nxt = push_word;
				v1_nxt = 1'h1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			d0_r <= 9'h000;
			d1_r <= 9'h000;
			v0_r <= 1'h0;
			v1_r <= 1'h0;
		end else begin
			d0_r <= d0_nxt;
			d1_r <= d1_nxt;
			v0_r <= v0_nxt;
			v1_r <= v1_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	sbf_dev_state_type st_r;
	sbf_dev_state_type st_nxt;
	logic [3:0]        cnt_r;
	logic [3:0]        cnt_nxt;
	logic [7:0]        sh_r;
	logic [7:0]        sh_nxt;
	logic              first_r;
	logic              first_nxt;
	logic              dir_r;
	logic              dir_nxt;
	logic              oe_r;
	logic              oe_nxt;
	logic              take_r;
	logic              take_nxt;
	logic              stop_r;
	logic              stop_nxt;
	logic              pend_r;
	logic              pend_nxt;
	logic              stby_r;
	logic              stby_nxt;

	assign push_word = {first_r, sh_r};

	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		sh_nxt    = sh_r;
		first_nxt = first_r;
		dir_nxt   = dir_r;
		oe_nxt    = oe_r;
		take_nxt  = 1'h0;
		stop_nxt  = 1'h0;
		pend_nxt  = pend_r;
		stby_nxt  = stby_r;
		push      = 1'h0;
		if (pend_r && !core_busy_in) begin
			stby_nxt = 1'h1;
			pend_nxt = 1'h0;
		end
		if (stop_ev) begin
			st_nxt   = SBF_DS_IDLE;
			oe_nxt   = 1'h0;
			stop_nxt = 1'h1;
			pend_nxt = 1'h1;
		end else if (start_ev) begin
			oe_nxt   = 1'h0;
			pend_nxt = 1'h0;
			if (core_busy_in) begin
				st_nxt = SBF_DS_IGNORE;
			end else begin
				st_nxt    = SBF_DS_RX;
				cnt_nxt   = 4'h0;
				first_nxt = 1'h1;
				stby_nxt  = 1'h0;
			end
		end else begin
			case (st_r)
				SBF_DS_RX: begin
					if (scl_rise) begin
						// Data is taken only at the rising clock edge.
						sh_nxt  = {sh_r[6:0], sda_f_r};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == `SBF_WORD_BITS) begin
						if (first_r && !addr_hit(sh_r, dev_sel_in)) begin
							st_nxt   = SBF_DS_IDLE;
							stby_nxt = 1'h1;
						end else if (v1_r) begin
							// No room: withholding the acknowledge keeps the word from being lost.
							st_nxt = SBF_DS_IDLE;
						end else begin
							push    = 1'h1;
							oe_nxt  = 1'h1;
							dir_nxt = first_r ? sh_r[0] : dir_r;
							st_nxt  = SBF_DS_ACK;
						end
					end
				end
				SBF_DS_ACK: begin
					if (scl_fall) begin
						cnt_nxt = 4'h0;
						if (dir_r) begin
							st_nxt   = SBF_DS_TX;
							sh_nxt   = tx_data_in;
							take_nxt = 1'h1;
							oe_nxt   = !tx_data_in[7];
						end else begin
							oe_nxt    = 1'h0;
							st_nxt    = SBF_DS_RX;
							first_nxt = 1'h0;
						end
					end
				end
				SBF_DS_TX: begin
					if (scl_rise) begin
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (cnt_r == `SBF_WORD_BITS) begin
							oe_nxt = 1'h0;
							st_nxt = SBF_DS_RDACK;
						end else begin
							sh_nxt = {sh_r[6:0], 1'h0};
							oe_nxt = !sh_r[6];
						end
					end
				end
				SBF_DS_RDACK: begin
					if (scl_rise) begin
						st_nxt = sda_f_r ? SBF_DS_IDLE : SBF_DS_ACK;
					end
				end
				SBF_DS_IDLE, SBF_DS_IGNORE: begin
					st_nxt = st_r;
				end
				default: begin
					st_nxt = SBF_DS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r    <= SBF_DS_IDLE;
			cnt_r   <= 4'h0;
			sh_r    <= 8'h00;
			first_r <= 1'h0;
			dir_r   <= 1'h0;
			oe_r    <= 1'h0;
			take_r  <= 1'h0;
			stop_r  <= 1'h0;
			pend_r  <= 1'h0;
			stby_r  <= 1'h1;
		end else begin
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			first_r <= first_nxt;
			dir_r   <= dir_nxt;
			oe_r    <= oe_nxt;
			take_r  <= take_nxt;
			stop_r  <= stop_nxt;
			pend_r  <= pend_nxt;
			stby_r  <= stby_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign link.dev_sda_out = 1'h0;
	assign link.dev_sda_oe  = oe_r;
	assign rx_data_out      = d0_r[7:0];
	assign rx_first_out     = d0_r[8];
	assign rx_valid_out     = v0_r;
	assign tx_take_out      = take_r;
	assign dir_read_out     = dir_r;
	assign stop_out         = stop_r;
	assign standby_out      = stby_r;

endmodule

// ### hw/sbf_host.sv
`timescale 1ns/1ns
`include "sbf_defs.svh"
module sbf_host
	import sbf_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Two-wire link.
	sbf_link_if.host         link,
	// Command port.
	input  wire logic        cmd_valid_in,
	input  wire sbf_cmd_type cmd_code_in,
	input  wire logic [7:0]  cmd_data_in,
	input  wire logic        cmd_ack_in,
	output logic             cmd_ready_out,
	// Response port.
	output logic             rsp_valid_out,
	output logic [7:0]       rsp_data_out,
	output logic             rsp_nack_out
);

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [3:0] QTR_LAST = 4'(`SBF_QTR_CYC - 1);

	logic [2:0] sda_s_r;
	logic [2:0] sda_s_nxt;
	logic       sda_f_r;
	logic       sda_f_nxt;

	sbf_host_state_type st_r;
	sbf_host_state_type st_nxt;
	sbf_cmd_type        op_r;
	sbf_cmd_type        op_nxt;
	logic [3:0]         tc_r;
	logic [3:0]         tc_nxt;
	logic [1:0]         q_r;
	logic [1:0]         q_nxt;
	logic [3:0]         idx_r;
	logic [3:0]         idx_nxt;
	logic [7:0]         sh_r;
	logic [7:0]         sh_nxt;
	logic               ack_r;
	logic               ack_nxt;
	logic               nack_r;
	logic               nack_nxt;
	logic               scl_r;
	logic               scl_nxt;
	logic               oe_r;
	logic               oe_nxt;
	logic               rdy_r;
	logic               rdy_nxt;
	logic               rv_r;
	logic               rv_nxt;
	logic               low_want;
	logic               q_end;

	////////////////////////////////////////////////////////////////////////////////
	// Data line level seen by the host; the clock line is its own output.
	always_comb begin
		sda_s_nxt = {sda_s_r[1:0], link.sda};
		sda_f_nxt = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sda_s_r <= 3'h7;
			sda_f_r <= 1'h1;
		end else begin
			sda_s_r <= sda_s_nxt;
			sda_f_r <= sda_f_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign q_end = (tc_r == QTR_LAST);

	// Pull level in quarters 1..3; quarter 0 only lowers the clock so write and read data never move with it high.
	always_comb begin
		case (op_r)
			SBF_CMD_START:   low_want = (q_r == 2'h3);
			SBF_CMD_STOP:    low_want = (q_r != 2'h3);
			SBF_CMD_WRITE:   low_want = (idx_r < `SBF_ACK_SLOT) && !sh_r[7];
			SBF_CMD_READ:    low_want = (idx_r == `SBF_ACK_SLOT) && ack_r;
			default:         low_want = 1'h0;
		endcase
	end

	always_comb begin
		st_nxt   = st_r;
		op_nxt   = op_r;
		tc_nxt   = tc_r;
		q_nxt    = q_r;
		idx_nxt  = idx_r;
		sh_nxt   = sh_r;
		ack_nxt  = ack_r;
		nack_nxt = nack_r;
		scl_nxt  = scl_r;
		oe_nxt   = oe_r;
		rv_nxt   = 1'h0;
		case (st_r)
			SBF_HS_IDLE: begin
				if (cmd_valid_in) begin
					st_nxt   = SBF_HS_RUN;
					op_nxt   = cmd_code_in;
					sh_nxt   = cmd_data_in;
					ack_nxt  = cmd_ack_in;
					nack_nxt = 1'h0;
					idx_nxt  = 4'h0;
					tc_nxt   = 4'h0;
					q_nxt    = 2'h0;
					scl_nxt  = 1'h0;
				end
			end
			SBF_HS_RUN: begin
				scl_nxt = (q_r >= 2'h2);
				if (q_r != 2'h0) begin
					oe_nxt = low_want;
				end
				tc_nxt = q_end ? 4'h0 : tc_r + 4'h1;
				if (q_end) begin
					q_nxt = q_r + 2'h1;
					if (q_r == 2'h2 && op_r == SBF_CMD_RECOVER && sda_f_r) begin
						// Start in this same high phase: after one more clock fall the
						// target could pull the data line again and swallow the start.
						op_nxt = SBF_CMD_START;
					end
					if (q_r == 2'h3) begin
						case (op_r)
							SBF_CMD_WRITE, SBF_CMD_READ: begin
								if (idx_r == `SBF_ACK_SLOT) begin
									nack_nxt = sda_f_r;
									st_nxt   = SBF_HS_IDLE;
									rv_nxt   = 1'h1;
								end else begin
									sh_nxt = {sh_r[6:0], sda_f_r};
								end
								idx_nxt = idx_r + 4'h1;
							end
							SBF_CMD_RECOVER: begin
								// Pulse budget spent with data still held low: end with a start anyway.
								idx_nxt = idx_r + 4'h1;
								if (idx_r == `SBF_REC_PULSES - 4'h1) begin
									op_nxt   = SBF_CMD_START;
									nack_nxt = 1'h1;
								end
							end
							default: begin
								st_nxt = SBF_HS_IDLE;
								rv_nxt = 1'h1;
							end
						endcase
					end
				end
			end
			default: begin
				st_nxt = SBF_HS_IDLE;
			end
		endcase
		rdy_nxt = (st_nxt == SBF_HS_IDLE) && !(st_r == SBF_HS_IDLE && cmd_valid_in);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_r   <= SBF_HS_IDLE;
			op_r   <= SBF_CMD_START;
			tc_r   <= 4'h0;
			q_r    <= 2'h0;
			idx_r  <= 4'h0;
			sh_r   <= 8'h00;
			ack_r  <= 1'h0;
			nack_r <= 1'h0;
			scl_r  <= 1'h1;
			oe_r   <= 1'h0;
			rdy_r  <= 1'h1;
			rv_r   <= 1'h0;
		end else begin
			st_r   <= st_nxt;
			op_r   <= op_nxt;
			tc_r   <= tc_nxt;
			q_r    <= q_nxt;
			idx_r  <= idx_nxt;
			sh_r   <= sh_nxt;
			ack_r  <= ack_nxt;
			nack_r <= nack_nxt;
			scl_r  <= scl_nxt;
			oe_r   <= oe_nxt;
			rdy_r  <= rdy_nxt;
			rv_r   <= rv_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign link.scl          = scl_r;
	assign link.host_sda_out = 1'h0;
	assign link.host_sda_oe  = oe_r;
	assign cmd_ready_out     = rdy_r;
	assign rsp_valid_out     = rv_r;
	assign rsp_data_out      = sh_r;
	assign rsp_nack_out      = nack_r;

endmodule

// ### sim/sbf_link_assertions.sv
`timescale 1ns/1ns
module sbf_link_assertions (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Two-wire link.
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_out,
	input wire logic host_sda_oe,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe
);
	logic       scl_r, sda_r, rd_r, first_r, nib_r;
	logic [3:0] cnt_r, low_r;
	logic [6:0] sh_r;
	logic       rise, start_ev, stop_ev;

	assign rise     = scl && !scl_r;
	assign start_ev = scl && scl_r && sda_r && !sda;
	assign stop_ev  = scl && scl_r && !sda_r && sda;

	// Bit count since start runs 1..9, so the ninth pulse can be told from idle.
	always_ff @(posedge clk_in) begin
		scl_r <= scl;
		sda_r <= sda;
		low_r <= scl ? 4'h0 : ((low_r == 4'hf) ? low_r : low_r + 4'h1);
		if (!rst_n_in || start_ev) begin
			cnt_r   <= 4'h0;
			first_r <= rst_n_in;
		end else if (rise) begin
			cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
			sh_r  <= {sh_r[5:0], sda};
			if (first_r && cnt_r == 4'h7) begin
				rd_r  <= sda;
				nib_r <= (sh_r[6:3] == 4'ha);
			end
			if (cnt_r == 4'h8) begin
				first_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	dev_low_only_a: assert property (dev_sda_oe |-> !dev_sda_out)
		else $error("target drove sda high");
	host_low_only_a: assert property (host_sda_oe |-> !host_sda_out)
		else $error("controller drove sda high");
	dev_edge_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("target changed sda with scl high");
	ack_slot_a: assert property (rise && dev_sda_oe && !rd_r |-> cnt_r == 4'h8)
		else $error("target pulled sda outside the ninth pulse");
	nomatch_quiet_a: assert property (rise && cnt_r == 4'h8 && first_r && !nib_r |-> !dev_sda_oe [*8])
		else $error("target acknowledged a foreign address");
	ack_hold_a: assert property (rise && cnt_r == 4'h8 && dev_sda_oe |-> dev_sda_oe [*8])
		else $error("acknowledge dropped in the ninth pulse");
	ack_release_a: assert property ($fell(scl) && cnt_r == 4'h9 && dev_sda_oe && !rd_r |-> ##[1:8] !dev_sda_oe)
		else $error("acknowledge not released");
	stop_quiet_a: assert property (stop_ev |=> !dev_sda_oe [*8])
		else $error("target drove sda after stop");
	drive_lag_a: assert property ($rose(dev_sda_oe) |-> low_r inside {[4'h2:4'h9]})
		else $error("target drive not timed from sampled scl fall");

	ack_seen_c: cover property (rise && cnt_r == 4'h8 && dev_sda_oe);
	nomatch_seen_c: cover property (rise && cnt_r == 4'h8 && first_r && !nib_r);
	stop_seen_c: cover property (stop_ev);
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench
	import sbf_pkg::*;
;
	logic        clk_in = 1'b0, host_rst_n = 1'b0, dev_rst_n = 1'b0;
	logic        cmd_valid = 1'b0, cmd_ack = 1'b0, busy = 1'b0, rx_ready = 1'b0;
	sbf_cmd_type cmd_code = SBF_CMD_START;
	logic [7:0]  cmd_data = 8'h00, tx_data = 8'h00, rsp_data, rx_data, adw, adr, d;
	logic [2:0]  sel = 3'h0;
	logic        cmd_ready, rsp_valid, rsp_nack, rx_first, rx_valid, rx2_valid;
	logic        stop_p, standby, dir_rd, nk, take, scl2 = 1'b1, oe2 = 1'b0;
	logic [9:0]  rsp_q[$], e;
	logic [8:0]  rx_q[$];
	int          err_total = 0, total_checks = 0, cyc = 0, stops = 0, takes = 0;

	sbf_link_if link ();
	sbf_link_if link2 ();
	assign link2.scl = scl2;
	assign link2.host_sda_out = 1'b0;
	assign link2.host_sda_oe = oe2;

	sbf_host sbf_host_i (.clk_in(clk_in), .rst_n_in(host_rst_n), .link(link.host),
		.cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_data_in(cmd_data),
		.cmd_ack_in(cmd_ack), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
		.rsp_data_out(rsp_data), .rsp_nack_out(rsp_nack));
	sbf_dev sbf_dev_i (.clk_in(clk_in), .rst_n_in(dev_rst_n), .link(link.dev), .dev_sel_in(sel),
		.core_busy_in(busy), .rx_data_out(rx_data), .rx_first_out(rx_first),
		.rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .tx_data_in(tx_data), .tx_take_out(take),
		.dir_read_out(dir_rd), .stop_out(stop_p), .standby_out(standby));
	// Second target faces a bench driver that may break the framing on purpose.
	sbf_dev sbf_dev2_i (.clk_in(clk_in), .rst_n_in(dev_rst_n), .link(link2.dev),
		.dev_sel_in(sel), .core_busy_in(1'b0), .rx_data_out(), .rx_first_out(),
		.rx_valid_out(rx2_valid), .rx_ready_in(1'b1), .tx_data_in(8'h00), .tx_take_out(),
		.dir_read_out(), .stop_out(), .standby_out());
	sbf_link_assertions sbf_link_assertions_i (.clk_in(clk_in), .rst_n_in(dev_rst_n),
		.scl(link.scl), .sda(link.sda), .host_sda_out(link.host_sda_out),
		.host_sda_oe(link.host_sda_oe), .dev_sda_out(link.dev_sda_out),
		.dev_sda_oe(link.dev_sda_oe));

	always #25 clk_in = ~clk_in;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Expectation word: bit 9 says whether the data byte is compared, bit 8 is no-acknowledge.
	task automatic cmd(input sbf_cmd_type c, input logic [7:0] dv, input logic a,
		input logic [9:0] exp, input logic wait_rsp);
		int n;
		@(negedge clk_in);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_data = dv;
		cmd_ack = a;
		@(posedge clk_in);
		while (cmd_ready !== 1'b1) @(posedge clk_in);
		if (wait_rsp) rsp_q.push_back(exp);
		@(negedge clk_in);
		cmd_valid = 1'b0;
		n = 0;
		while (wait_rsp && rsp_valid !== 1'b1 && n < 400) begin
			@(posedge clk_in);
			n++;
		end
		if (n == 400) check(10'h0, 10'h1);
		@(negedge clk_in);
	endtask

	task automatic fr(input sbf_cmd_type c);
		cmd(c, 8'h00, 1'b0, 10'h000, 1'b1);
	endtask

	task automatic wr(input logic [7:0] dv, input logic nack, input logic first);
		if (!nack) rx_q.push_back({first, dv});
		cmd(SBF_CMD_WRITE, dv, 1'b0, {1'b1, nack, dv}, 1'b1);
	endtask

	task automatic rd(input logic a);
		cmd(SBF_CMD_READ, 8'h00, a, {1'b1, !a, tx_data}, 1'b1);
	endtask

	// One bit on the second link at a 400 ns period; sda is sampled mid-high.
	task automatic bit2(input logic b, output logic seen);
		oe2 = !b;
		#200 scl2 = 1'b1;
		#100 seen = link2.sda;
		#100 scl2 = 1'b0;
	endtask

	task automatic word2(input logic [7:0] w, output logic nack);
		for (int i = 7; i >= 0; i--) bit2(w[i], nack);
		bit2(1'b1, nack);
	endtask

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
		if (stop_p === 1'b1) stops++;
		if (take === 1'b1) takes++;
		if (rsp_valid === 1'b1) begin
			e = rsp_q.pop_front();
			check({1'b0, rsp_nack, e[9] ? rsp_data : e[7:0]}, {1'b0, e[8:0]});
		end
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			check({1'b0, rx_first, rx_data}, {1'b0, rx_q.pop_front()});
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(48046));
		sel = 3'($urandom);
		tx_data = 8'($urandom);
		d = 8'($urandom);
		adw = {4'ha, sel, 1'b0};
		adr = {4'ha, sel, 1'b1};
		repeat (5) @(negedge clk_in);
		host_rst_n = 1'b1;
		dev_rst_n = 1'b1;
		repeat (10) @(negedge clk_in);
		check({9'h0, standby}, 10'h1);
		scl2 = 1'b0;
		word2(adw, nk);
		check({8'h0, nk, rx2_valid}, 10'h2);
		oe2 = 1'b0;
		#100 scl2 = 1'b1;
		#100 oe2 = 1'b1;
		#100 scl2 = 1'b0;
		word2(adw, nk);
		check({9'h0, nk}, 10'h0);
		oe2 = 1'b1;
		#200 scl2 = 1'b1;
		#100 oe2 = 1'b0;
		$display("test framing done");
		fr(SBF_CMD_START);
		wr(adw, 1'b0, 1'b1);
		wr(d, 1'b0, 1'b0);
		wr(~d, 1'b1, 1'b0);
		fr(SBF_CMD_STOP);
		rx_ready = 1'b1;
		repeat (8) @(negedge clk_in);
		check({8'h0, rx_valid, standby}, 10'h1);
		$display("test write done");
		fr(SBF_CMD_START);
		wr(adr, 1'b0, 1'b1);
		check({8'h0, dir_rd, standby}, 10'h2);
		rd(1'b1);
		rd(1'b0);
		fr(SBF_CMD_STOP);
		repeat (4) @(negedge clk_in);
		check({9'h0, standby}, 10'h1);
		check(10'(stops), 10'h2);
		check(10'(takes), 10'h2);
		$display("test read done");
		for (int k = 0; k < 2; k++) begin
			fr(SBF_CMD_START);
			wr(k ? {4'hb, sel, 1'b0} : {4'ha, ~sel, 1'b0}, 1'b1, 1'b0);
			check({9'h0, standby}, 10'h1);
			fr(SBF_CMD_STOP);
		end
		$display("test mismatch done");
		fr(SBF_CMD_START);
		wr(adw, 1'b0, 1'b1);
		busy = 1'b1;
		fr(SBF_CMD_STOP);
		repeat (20) @(negedge clk_in);
		check({9'h0, standby}, 10'h0);
		fr(SBF_CMD_START);
		wr(adw, 1'b1, 1'b0);
		fr(SBF_CMD_STOP);
		busy = 1'b0;
		repeat (8) @(negedge clk_in);
		check({9'h0, standby}, 10'h1);
		$display("test busy done");
		// Bit five low makes the target hold sda down when the controller is reset.
		tx_data = 8'($urandom) & 8'hdf;
		fr(SBF_CMD_START);
		wr(adr, 1'b0, 1'b1);
		cmd(SBF_CMD_READ, 8'h00, 1'b0, 10'h000, 1'b0);
		repeat (51) @(negedge clk_in);
		host_rst_n = 1'b0;
		repeat (4) @(negedge clk_in);
		host_rst_n = 1'b1;
		check({9'h0, link.sda}, 10'h0);
		fr(SBF_CMD_RECOVER);
		wr(adw, 1'b0, 1'b1);
		fr(SBF_CMD_STOP);
		$display("test recovery done");
		check(10'(rsp_q.size() + rx_q.size()), 10'h0);
		close_out();
	end
endmodule
